//--- core/spiwl_params.svh
/*
 * Constants of the serial wiper-latch block: word size, preset code,
 * tap count and input timing.
 * Assumes inclusion by its bare name from the package and the modules.
 */
`ifndef SPIWL_PARAMS_SVH
`define SPIWL_PARAMS_SVH

`define SPIWL_WORD_BITS 8
`define SPIWL_TAPS 256
`define SPIWL_PRESET_CODE 8'h80
`define SPIWL_ZERO_CODE 8'h00
`define SPIWL_CLK_PERIOD_NS 25
`define SPIWL_MIN_PHASE_NS 75
`define SPIWL_MIN_PHASE_CYC ((`SPIWL_MIN_PHASE_NS + `SPIWL_CLK_PERIOD_NS - 1) / `SPIWL_CLK_PERIOD_NS)

`endif

//--- core/spiwl_pkg.sv
/*
 * Types shared by the serial wiper-latch block.
 * Assumes spiwl_params.svh is on the include path.
 */
`include "spiwl_params.svh"

package spiwl_pkg;
  typedef logic [`SPIWL_WORD_BITS-1:0] spiwl_code_type;
  typedef logic [`SPIWL_TAPS-1:0] spiwl_taps_type;
  typedef enum logic [2:0] {
    SPIWL_IDLE  = 3'b001,
    SPIWL_SHIFT = 3'b010,
    SPIWL_LOAD  = 3'b100
  } spiwl_state_type;
endpackage

//--- core/spiwl_tap_if.sv
/*
 * Carrier between the serial front end and the tap decoder.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface spiwl_tap_if;
  import spiwl_pkg::*;
  spiwl_code_type code;
  spiwl_taps_type sel;
  modport src (output code, input sel);
  modport dec (input code, output sel);
endinterface

//--- core/spiwl_tap_decode.sv
/*
 * Registered one-of-256 decoder from the wiper latch code to a tap select.
 * Assumes a synchronous active-high reset on the same clock as the latch.
 */
`timescale 1ns/1ps
`include "spiwl_params.svh"

module spiwl_tap_decode (
  input wire logic clk,
  input wire logic rst,
  spiwl_tap_if.dec tif
);
  import spiwl_pkg::*;

  spiwl_taps_type sel_r;
  spiwl_taps_type sel_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < `SPIWL_TAPS; gi++) begin : g_tap
      // Code n picks tap n; tap 0 is the B terminal
      assign sel_nxt[gi] = (tif.code == spiwl_code_type'(gi));
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_r <= spiwl_taps_type'(1) << `SPIWL_PRESET_CODE;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  assign tif.sel = sel_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_one_tap;
    $onehot(sel_r);
  endproperty
  a_one_tap: assert property (p_one_tap) else $error("tap select not one-hot");

  property p_code_tap;
    ##1 sel_r[$past(tif.code)] == 1'b1;
  endproperty
  a_code_tap: assert property (p_code_tap) else $error("tap does not follow code");

  property p_zero_b;
    tif.code == `SPIWL_ZERO_CODE |=> sel_r[0];
  endproperty
  a_zero_b: assert property (p_zero_b) else $error("code zero not on B terminal");
endmodule

//--- core/spiwl_top.sv
/*
 * Three-wire serial receive path of a 256-position digital potentiometer:
 * shift register, wiper latch, open-drain chain output and tap decode.
 * Assumes serial clock, chip select, data and interface select arrive from
 * pins asynchronous to clk; each serial clock phase lasts at least
 * SPIWL_MIN_PHASE_CYC clk cycles.
 */
`timescale 1ns/1ps
`include "spiwl_params.svh"

module spiwl_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic iface_select,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic chain_out,
  output logic chain_out_oe_n,
  output spiwl_pkg::spiwl_code_type wiper_latch,
  output spiwl_pkg::spiwl_taps_type tap_sel,
  output logic busy
);
  import spiwl_pkg::*;

  // Two-stage synchronisers plus a third stage for edge detection
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic cs_n_s1_r, cs_n_s2_r;
  logic din_s1_r, din_s2_r;
  logic sel_s1_r, sel_s2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      cs_n_s1_r <= 1'b1;
      cs_n_s2_r <= 1'b1;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
    end else begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_n_s1_r <= cs_n;
      cs_n_s2_r <= cs_n_s1_r;
      din_s1_r <= serial_in;
      din_s2_r <= din_s1_r;
      sel_s1_r <= iface_select;
      sel_s2_r <= sel_s1_r;
    end
  end

  logic sclk_rise;
  logic spi_on;
  assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
  assign spi_on = ~sel_s2_r;

  spiwl_state_type state_r, state_nxt;
  spiwl_code_type shift_r, shift_nxt;
  spiwl_code_type wiper_r, wiper_nxt;
  logic oe_n_r, oe_n_nxt;
  logic low_r, low_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    wiper_nxt = wiper_r;
    oe_n_nxt = oe_n_r;
    low_nxt = 1'b0;
    busy_nxt = 1'b0;
    case (state_r)
      SPIWL_IDLE: begin
        if (spi_on && !cs_n_s2_r) begin
          state_nxt = SPIWL_SHIFT;
          busy_nxt = 1'b1;
        end
      end
      SPIWL_SHIFT: begin
        busy_nxt = 1'b1;
        if (!spi_on) begin
          state_nxt = SPIWL_IDLE;
          busy_nxt = 1'b0;
        end else if (cs_n_s2_r) begin
          state_nxt = SPIWL_LOAD;
        end else if (sclk_rise) begin
          // MSB first; oldest bits leave at the top
          shift_nxt = {shift_r[`SPIWL_WORD_BITS-2:0], din_s2_r};
          // Pin follows the new top bit, low for a zero
          oe_n_nxt = shift_r[`SPIWL_WORD_BITS-2];
        end
      end
      SPIWL_LOAD: begin
        wiper_nxt = shift_r;
        state_nxt = SPIWL_IDLE;
      end
      default: begin
        state_nxt = SPIWL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SPIWL_IDLE;
      shift_r <= `SPIWL_ZERO_CODE;
      wiper_r <= `SPIWL_PRESET_CODE;
      oe_n_r <= 1'b1;
      low_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      wiper_r <= wiper_nxt;
      oe_n_r <= oe_n_nxt;
      low_r <= low_nxt;
      busy_r <= busy_nxt;
    end
  end

  spiwl_tap_if tif ();
  assign tif.code = wiper_r;

  spiwl_tap_decode u_dec (
    .clk(clk),
    .rst(rst),
    .tif(tif)
  );

  assign chain_out = low_r;
  assign chain_out_oe_n = oe_n_r;
  assign wiper_latch = wiper_r;
  assign tap_sel = tif.sel;
  assign busy = busy_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_edge_in_shift;
    state_r == SPIWL_SHIFT && spi_on && !cs_n_s2_r && sclk_rise;
  endsequence

  property p_shift_in;
    s_edge_in_shift |=> shift_r == {$past(shift_r[6:0]), $past(din_s2_r)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted in");

  property p_msb_first;
    s_edge_in_shift |=> shift_r[0] == $past(din_s2_r);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("new bit not at bottom");

  property p_idle_hold;
    state_r == SPIWL_IDLE |=> $stable(shift_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("shift moved while idle");

  sequence s_load_req;
    state_r == SPIWL_SHIFT && spi_on && cs_n_s2_r;
  endsequence

  sequence s_load_done;
    state_r == SPIWL_LOAD ##1 wiper_r == $past(shift_r, 2);
  endsequence

  property p_load;
    s_load_req |=> s_load_done;
  endproperty
  a_load: assert property (p_load) else $error("latch not loaded on select rise");

  property p_latch_only_load;
    !$stable(wiper_r) |-> $past(state_r) == SPIWL_LOAD;
  endproperty
  a_latch_only_load: assert property (p_latch_only_load) else $error("latch moved outside load");

  property p_select_off;
    sel_s2_r |=> state_r == SPIWL_IDLE;
  endproperty
  a_select_off: assert property (p_select_off) else $error("active with two-wire select");

  property p_chain_top;
    s_edge_in_shift |=> chain_out_oe_n == shift_r[7];
  endproperty
  a_chain_top: assert property (p_chain_top) else $error("chain output not top bit");

  property p_open_drain;
    chain_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("chain output drives high");

  property p_keep_last;
    s_edge_in_shift |=> shift_r[7:1] == $past(shift_r[6:0]);
  endproperty
  a_keep_last: assert property (p_keep_last) else $error("old bits not dropped at top");

  property p_preset;
    rst |=> wiper_r == `SPIWL_PRESET_CODE;
  endproperty
  a_preset: assert property (disable iff (1'b0) p_preset) else $error("no midscale preset");

  property p_abort;
    state_r == SPIWL_SHIFT && !spi_on |=> state_r == SPIWL_IDLE && $stable(wiper_r);
  endproperty
  a_abort: assert property (p_abort) else $error("frame not aborted on select");

  property p_busy;
    busy == (state_r != SPIWL_IDLE);
  endproperty
  a_busy: assert property (p_busy) else $error("busy does not match frame");
endmodule

//--- tb/spiwl_host_model.sv
/*
 * Host serial controller for the wiper-latch block.
 * Assumes the caller owns clk; pins change 1 ns after a rising edge.
 */
`timescale 1ns/1ps

module spiwl_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic serial_in
);
  localparam int PHASE = 4; // Long phases for pulled-up chain nodes

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Frame of nbits, far device word first, MSB first
  task automatic send(input logic [31:0] data, input int nbits, input logic framed);
    tick(1);
    cs_n = ~framed;
    tick(PHASE);
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = data[i];
      tick(PHASE);
      sclk = 1'b1;
      tick(PHASE);
      sclk = 1'b0;
    end
    tick(PHASE);
    cs_n = 1'b1; // Single rise after all chained bits
    serial_in = ~serial_in;
    tick(PHASE);
  endtask
endmodule

//--- tb/testbench.sv
/*
 * Self-checking bench: two chained blocks driven by the host model.
 * Assumes the design files and spiwl_params.svh are compiled first.
 */
`timescale 1ns/1ps

module testbench;
  import spiwl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iface_select = 1'b0;
  logic sclk, cs_n, serial_in, chain_out, oe_n, pin, busy;
  spiwl_code_type near_code, far_code;
  spiwl_taps_type near_taps, far_taps;
  int fails = 0;
  int n_tests = 0;

  always #12.5 clk = ~clk;
  // Pull-up on the chain node
  assign pin = oe_n ? 1'b1 : 1'b0;

  spiwl_host_model spiwl_host_model_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in));
  spiwl_top spiwl_top_inst (.clk(clk), .rst(rst), .iface_select(iface_select),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .chain_out(chain_out),
    .chain_out_oe_n(oe_n), .wiper_latch(near_code), .tap_sel(near_taps), .busy(busy));
  spiwl_top spiwl_top_far_inst (.clk(clk), .rst(rst), .iface_select(iface_select),
    .sclk(sclk), .cs_n(cs_n), .serial_in(pin), .chain_out(), .chain_out_oe_n(),
    .wiper_latch(far_code), .tap_sel(far_taps), .busy());

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_taps(input spiwl_taps_type got, input spiwl_taps_type exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Latches, one-hot taps and chain node after a frame
  task automatic check_all(input spiwl_code_type n, input spiwl_code_type f, input logic p);
    tick(8);
    check_val(near_code, n);
    check_taps(near_taps, spiwl_taps_type'(1) << n);
    check_val(far_code, f);
    check_taps(far_taps, spiwl_taps_type'(1) << f);
    check_val({7'h0, pin}, {7'h0, p});
    check_val({7'h0, chain_out}, 8'h00);
  endtask

  task automatic test_reset();
    check_val({7'h0, busy}, 8'h00);
    check_all(8'h80, 8'h80, 1'b1);
    $display("test_reset done");
  endtask

  task automatic test_chain();
    fork
      spiwl_host_model_inst.send(32'h5a00, 16, 1'b1);
      begin
        tick(12);
        check_val({7'h0, busy}, 8'h01);
      end
    join
    check_all(8'h00, 8'h5a, 1'b0);
    spiwl_host_model_inst.send(32'hff01, 16, 1'b1);
    check_all(8'h01, 8'hff, 1'b0);
    $display("test_chain done");
  endtask

  task automatic test_surplus();
    spiwl_host_model_inst.send(32'h112233, 24, 1'b1);
    check_all(8'h33, 8'h22, 1'b0);
    $display("test_surplus done");
  endtask

  task automatic test_ignored();
    spiwl_host_model_inst.send(32'hc3c3, 16, 1'b0);
    check_all(8'h33, 8'h22, 1'b0);
    iface_select = 1'b1;
    tick(4);
    spiwl_host_model_inst.send(32'h0f0f, 16, 1'b1);
    check_all(8'h33, 8'h22, 1'b0);
    iface_select = 1'b0;
    tick(4);
    spiwl_host_model_inst.send(32'h0180, 16, 1'b1);
    check_all(8'h80, 8'h01, 1'b1);
    fork
      spiwl_host_model_inst.send(32'h5555, 16, 1'b1);
      begin
        tick(40);
        iface_select = 1'b1;
      end
    join
    iface_select = 1'b0;
    tick(4);
    check_all(8'h80, 8'h01, 1'b0);
    $display("test_ignored done");
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end

  initial begin
    tick(20);
    rst = 1'b0;
    tick(4);
    test_reset();
    test_chain();
    test_surplus();
    test_ignored();
    give_verdict();
  end
endmodule
